// ---- rtl/tid_decoder.sv ----
/*
 * 12-bit instruction decoder with a four-phase instruction cycle timer.
 * assumes program memory holds INSTR_IN steady across a cycle and the
 * executing core reports the outcome of conditional tests on COND_TRUE_IN.
 */
`timescale 1ns/10ps
module tid_decoder #(
    parameter int WORD_BITS = tid_pkg::WORD_W
) (
    input wire logic MCLK_IN,
    input wire logic RST_IN,
    input wire logic [11:0] INSTR_IN,
    input wire logic COND_TRUE_IN,
    output logic CYCLE_START_OUT,
    output logic [1:0] PHASE_OUT,
    output logic DEC_VALID_OUT,
    output logic [2:0] GROUP_OUT,
    output logic [5:0] OPCODE_OUT,
    output logic [5:0] BYTE_OP_OUT,
    output logic DEST_FILE_OUT,
    output logic [2:0] BIT_SEL_OUT,
    output logic [6:0] FILE_ADDR_OUT,
    output logic [8:0] LITERAL_OUT,
    output logic LIT_WIDE_OUT,
    output logic [1:0] CYCLES_OUT,
    output logic FLUSH_OUT
);

    if (WORD_BITS != tid_pkg::WORD_W) begin : g_width_check
        $error("only 12-bit instruction words are supported");
    end

    typedef struct packed {
        logic [1:0] phase;
        logic start;
        logic valid;
        tid_pkg::tid_dec_t dec;
        logic [1:0] cycles;
        logic flush;
        logic second;
    } tid_state_t;

    tid_pkg::tid_dec_t split;
    tid_state_t s_q;
    tid_state_t s_d;

    // pure field split; word is taken from memory on the same clock
    tid_field_split u_split (
        .word_in(INSTR_IN),
        .dec_out(split)
    );

    // phase counter, latch on last phase, cycle count resolution
    always_comb begin
        s_d = s_q;
        s_d.start = 1'b0;
        s_d.phase = s_q.phase + 2'h1;
        if (s_q.phase == tid_pkg::PHASE_LAST) begin
            s_d.start = 1'b1;
            if (s_q.second) begin
                // second cycle executes a discarded fetch, no new decode
                s_d.second = 1'b0;
                s_d.valid = 1'b0;
                s_d.flush = 1'b0;
            end else begin
                s_d.dec = split; // don't-care bits never reach a compare
                s_d.valid = 1'b1;
                s_d.cycles = split.is_jump ? tid_pkg::CYC_TWO : tid_pkg::CYC_ONE;
                s_d.flush = split.is_jump;
                s_d.second = split.is_jump;
            end
        end else if (s_q.phase == 2'h2 && s_q.valid && s_q.dec.is_skip && COND_TRUE_IN && !s_q.second) begin
            // test outcome known late in the cycle stretches it to two
            s_d.cycles = tid_pkg::CYC_TWO;
            s_d.flush = 1'b1;
            s_d.second = 1'b1;
        end
    end

    always_ff @(posedge MCLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign CYCLE_START_OUT = s_q.start;
    assign PHASE_OUT = s_q.phase;
    assign DEC_VALID_OUT = s_q.valid;
    assign GROUP_OUT = s_q.dec.group;
    assign OPCODE_OUT = s_q.dec.op;
    assign BYTE_OP_OUT = s_q.dec.byte_op;
    assign DEST_FILE_OUT = s_q.dec.dest_file;
    assign BIT_SEL_OUT = s_q.dec.bit_sel;
    assign FILE_ADDR_OUT = s_q.dec.file_addr;
    assign LITERAL_OUT = s_q.dec.literal;
    assign LIT_WIDE_OUT = s_q.dec.lit_wide;
    assign CYCLES_OUT = s_q.cycles;
    assign FLUSH_OUT = s_q.flush;

endmodule : tid_decoder

// ---- common/tid_pkg.sv ----
/*
 * package for the 12-bit instruction decoder: field positions, group and
 * opcode encodings, timing counts and the carrier struct.
 * assumes a single oscillator clock and no software-visible registers.
 */
package tid_pkg;

    localparam int WORD_W = 12;
    localparam int FILE_W = 5;
    localparam int BIT_W = 3;
    localparam int LIT_W = 8;
    localparam int LIT9_W = 9;
    // field positions inside the word
    localparam int DEST_POS = 5;
    localparam int BITSEL_LSB = 5;
    // oscillator periods per instruction cycle
    localparam int PHASES = 4;
    localparam logic [1:0] PHASE_LAST = 2'h3;
    localparam logic [6:0] FILE_ADDR_MAX = 7'h7F;
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    // special words inside the zero-top group
    localparam logic [11:0] W_NOP = 12'h000;
    localparam logic [11:0] W_OPTION = 12'h002;
    localparam logic [11:0] W_SLEEP = 12'h003;
    localparam logic [11:0] W_CLRWDT = 12'h004;

    typedef enum logic [2:0] {
        GRP_BYTE = 3'b001,
        GRP_BIT  = 3'b010,
        GRP_LIT  = 3'b100
    } tid_group_t;

    typedef enum logic [5:0] {
        OP_BYTE  = 6'h00,
        OP_BCF   = 6'h01,
        OP_BSF   = 6'h02,
        OP_BTFSC = 6'h03,
        OP_BTFSS = 6'h04,
        OP_RETLW = 6'h05,
        OP_CALL  = 6'h06,
        OP_GOTO  = 6'h07,
        OP_MOVLW = 6'h08,
        OP_IORLW = 6'h09,
        OP_ANDLW = 6'h0A,
        OP_XORLW = 6'h0B,
        OP_MISC  = 6'h0C
    } tid_op_t;

    typedef struct packed {
        tid_group_t group;
        tid_op_t op;
        logic [5:0] byte_op;
        logic dest_file;
        logic [2:0] bit_sel;
        logic [6:0] file_addr;
        logic [8:0] literal;
        logic lit_wide;
        logic is_skip;
        logic is_jump;
    } tid_dec_t;

endpackage : tid_pkg

// ---- rtl/tid_field_split.sv ----
/*
 * combinational field splitter: group and opcode from the top bits first,
 * then operands from the rest.
 * assumes a stable 12-bit word at its input.
 */
`timescale 1ns/10ps
module tid_field_split (
    input wire logic [11:0] word_in,
    output tid_pkg::tid_dec_t dec_out
);

    // top bits choose the group, then the operand fields are read
    always_comb begin
        dec_out = '0;
        dec_out.group = tid_pkg::GRP_LIT;
        dec_out.op = tid_pkg::OP_MISC;
        dec_out.file_addr = {2'h0, word_in[tid_pkg::FILE_W-1:0]};
        unique casez (word_in[11:8])
            4'b00??: begin
                // byte group, plus the fixed control words at the bottom
                dec_out.group = tid_pkg::GRP_BYTE;
                dec_out.op = tid_pkg::OP_BYTE;
                dec_out.byte_op = word_in[11:6];
                dec_out.dest_file = word_in[tid_pkg::DEST_POS];
                if (word_in[11:5] == 7'h00) begin
                    // control words: only the low five bits count
                    dec_out.group = tid_pkg::GRP_LIT;
                    dec_out.op = tid_pkg::OP_MISC;
                    dec_out.literal = {4'h0, word_in[4:0]};
                end
            end
            4'b01??: begin
                dec_out.group = tid_pkg::GRP_BIT;
                dec_out.bit_sel = word_in[tid_pkg::BITSEL_LSB +: tid_pkg::BIT_W];
                unique case (word_in[9:8])
                    2'h0: dec_out.op = tid_pkg::OP_BCF;
                    2'h1: dec_out.op = tid_pkg::OP_BSF;
                    2'h2: dec_out.op = tid_pkg::OP_BTFSC;
                    2'h3: dec_out.op = tid_pkg::OP_BTFSS;
                endcase
                dec_out.is_skip = word_in[9];
            end
            4'b101?: begin
                // wide literal: jump target takes nine bits
                dec_out.op = tid_pkg::OP_GOTO;
                dec_out.literal = word_in[8:0];
                dec_out.lit_wide = 1'b1;
                dec_out.is_jump = 1'b1;
            end
            default: begin
                dec_out.literal = {1'b0, word_in[7:0]};
                unique case (word_in[11:8])
                    4'h8: dec_out.op = tid_pkg::OP_RETLW;
                    4'h9: dec_out.op = tid_pkg::OP_CALL;
                    4'hC: dec_out.op = tid_pkg::OP_MOVLW;
                    4'hD: dec_out.op = tid_pkg::OP_IORLW;
                    4'hE: dec_out.op = tid_pkg::OP_ANDLW;
                    default: dec_out.op = tid_pkg::OP_XORLW;
                endcase
                dec_out.is_jump = (word_in[11:9] == 3'b100);
            end
        endcase
        // skip-capable byte ops: decf-skip and incf-skip
        if (dec_out.group == tid_pkg::GRP_BYTE) begin
            dec_out.is_skip = (word_in[11:6] == 6'h0B) || (word_in[11:6] == 6'h0F);
        end
    end

endmodule : tid_field_split

// ---- sim/tid_prog_mem.sv ----
/* program memory model: one whole 12-bit word per instruction cycle.
   assumes the decoder's phase output paces the fetch. */
`timescale 1ns/10ps
module tid_prog_mem (
    input wire logic clk_in,
    input wire logic [1:0] phase_in,
    input wire logic [11:0] next_in,
    output logic [11:0] word_out = 12'h000
);
    // load mid-cycle so the word is steady at the phase-3 sample
    always @(posedge clk_in) if (phase_in == 2'h1) word_out <= next_in;
endmodule : tid_prog_mem

// ---- sim/tid_decoder_chk.sv ----
/* checker for the decoder ports: phase timing, field extraction, dead cycles.
   assumes program memory holds the word steady across each cycle. */
`timescale 1ns/10ps
module tid_decoder_chk (
    input wire logic MCLK_IN,
    input wire logic RST_IN,
    input wire logic [11:0] INSTR_IN,
    input wire logic CYCLE_START_OUT,
    input wire logic [1:0] PHASE_OUT,
    input wire logic DEC_VALID_OUT,
    input wire logic [2:0] GROUP_OUT,
    input wire logic [2:0] BIT_SEL_OUT,
    input wire logic [6:0] FILE_ADDR_OUT,
    input wire logic [8:0] LITERAL_OUT,
    input wire logic LIT_WIDE_OUT,
    input wire logic [1:0] CYCLES_OUT
);
    default clocking @(posedge MCLK_IN); endclocking
    default disable iff (RST_IN);
    // fresh decode: start pulse with valid; $past sees the word taken
    wire fresh = CYCLE_START_OUT && DEC_VALID_OUT;
    a_phase_wrap: assert property (PHASE_OUT == 2'h3 |=> PHASE_OUT == 2'h0) else $error("no wrap");
    a_phase_step: assert property (PHASE_OUT != 2'h3 |=> PHASE_OUT == $past(PHASE_OUT) + 2'h1)
        else $error("phase skipped");
    a_start_once: assert property (CYCLE_START_OUT |-> PHASE_OUT == 2'h0 ##1 (!CYCLE_START_OUT) [*3])
        else $error("bad start pulse");
    a_fields_stand: assert property (DEC_VALID_OUT && PHASE_OUT != 2'h3 |=> $stable(FILE_ADDR_OUT)
        && $stable(LITERAL_OUT) && $stable(GROUP_OUT)) else $error("fields moved");
    a_file_low: assert property (fresh |-> FILE_ADDR_OUT == {2'b00, $past(INSTR_IN[4:0])})
        else $error("file address");
    a_bit_field: assert property (fresh && $past(INSTR_IN[11:10]) == 2'b01 |-> GROUP_OUT == 3'b010
        && BIT_SEL_OUT == $past(INSTR_IN[7:5])) else $error("bit field");
    a_goto_wide: assert property (fresh && $past(INSTR_IN[11:9]) == 3'b101 |-> LIT_WIDE_OUT
        && LITERAL_OUT == $past(INSTR_IN[8:0]) && CYCLES_OUT == 2'h2) else $error("wide literal");
    a_dead_cycle: assert property (DEC_VALID_OUT && CYCLES_OUT == 2'h2 && PHASE_OUT == 2'h3
        |=> !DEC_VALID_OUT) else $error("no dead cycle");
endmodule : tid_decoder_chk
bind tid_decoder tid_decoder_chk tid_decoder_chk_i (.MCLK_IN, .RST_IN, .INSTR_IN, .CYCLE_START_OUT,
    .PHASE_OUT, .DEC_VALID_OUT, .GROUP_OUT, .BIT_SEL_OUT, .FILE_ADDR_OUT, .LITERAL_OUT, .LIT_WIDE_OUT, .CYCLES_OUT);

// ---- sim/testbench.sv ----
/* self-checking bench: corner words then random words through the decoder.
   assumes a 10 MHz clock and the program memory model. */
`timescale 1ns/10ps
module testbench;
    logic MCLK_IN = 1'b0, RST_IN = 1'b1, COND_TRUE_IN = 1'b0;
    logic [11:0] INSTR_IN, next_word = 12'h000, cur = 12'h000, w;
    logic CYCLE_START_OUT, DEC_VALID_OUT, DEST_FILE_OUT, LIT_WIDE_OUT, FLUSH_OUT;
    logic [1:0] PHASE_OUT, CYCLES_OUT;
    logic [2:0] GROUP_OUT, BIT_SEL_OUT;
    logic [5:0] OPCODE_OUT, BYTE_OP_OUT;
    logic [6:0] FILE_ADDR_OUT;
    logic [8:0] LITERAL_OUT;
    logic [11:0] corner [10] = '{12'hBFF, 12'h9AB, 12'h8FF, 12'h7E5, 12'h2DF,
        12'h03F, 12'h1D0, 12'h000, 12'h004, 12'hFAA};
    int failures = 0, total_checks = 0, ticks = 0, k = 0;
    bit dead = 0, two, c;
    tid_decoder tid_decoder_i (.MCLK_IN, .RST_IN, .INSTR_IN, .COND_TRUE_IN, .CYCLE_START_OUT, .PHASE_OUT,
        .DEC_VALID_OUT, .GROUP_OUT, .OPCODE_OUT, .BYTE_OP_OUT, .DEST_FILE_OUT, .BIT_SEL_OUT, .FILE_ADDR_OUT,
        .LITERAL_OUT, .LIT_WIDE_OUT, .CYCLES_OUT, .FLUSH_OUT);
    tid_prog_mem tid_prog_mem_i (.clk_in(MCLK_IN), .phase_in(PHASE_OUT), .next_in(next_word), .word_out(INSTR_IN));
    // clock, and a cycle ceiling well above 300 four-period cycles
    always #50 MCLK_IN = ~MCLK_IN;
    always @(posedge MCLK_IN) begin
        ticks++;
        if (ticks == 3000) begin
            failures++;
            results();
        end
    end
    task chk(input logic [11:0] s, input logic [11:0] e);
        total_checks++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task results;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results
    // expectations from the top bits of the word
    function logic [2:0] egrp(input logic [11:0] x);
        if (x[11:10] == 2'b01) return 3'b010;
        return (x[11:10] == 2'b00 && x[9:5] != 5'h00) ? 3'b001 : 3'b100;
    endfunction : egrp
    function logic [5:0] eop(input logic [11:0] x);
        if (x[11:10] == 2'b01) return 6'h01 + 6'(x[9:8]);
        if (x[11:10] == 2'b00) return (x[9:5] == 5'h00) ? 6'h0C : 6'h00;
        if (x[11:9] == 3'b101) return 6'h07;
        return 6'(x[11:8]) - ((x[11:8] < 4'hA) ? 6'h03 : 6'h04);
    endfunction : eop
    function logic [8:0] elit(input logic [11:0] x);
        if (x[11:9] == 3'b101) return x[8:0];
        return (x[11:5] == 7'h00) ? {4'h0, x[4:0]} : {1'b0, x[7:0]};
    endfunction : elit
    // jumps always, skips only when the test holds
    function bit etwo(input logic [11:0] x, input bit t);
        return x[11:10] == 2'b10 || (t && (x[11:9] == 3'b011 || x[11:6] == 6'h0B || x[11:6] == 6'h0F));
    endfunction : etwo
    // one pass per instruction cycle; a refused word does not use up a corner case
    initial begin
        void'($urandom(32'h81cd));
        repeat (10) @(posedge MCLK_IN);
        RST_IN <= 1'b0;
        @(posedge MCLK_IN);
        for (int i = 0; i < 300; i++) begin
            @(negedge MCLK_IN);
            while (PHASE_OUT !== 2'h0) @(negedge MCLK_IN);
            chk(12'(DEC_VALID_OUT), 12'(!dead));
            if (!dead) begin
                chk(12'(GROUP_OUT), 12'(egrp(cur)));
                chk(12'(OPCODE_OUT), 12'(eop(cur)));
                chk(12'(FILE_ADDR_OUT), {7'h00, cur[4:0]});
                chk(12'(BIT_SEL_OUT), egrp(cur) == 3'b010 ? 12'(cur[7:5]) : 12'h000);
                if (egrp(cur) == 3'b001) chk(12'({BYTE_OP_OUT, DEST_FILE_OUT}), 12'(cur[11:5]));
                if (egrp(cur) == 3'b100) begin
                    chk(12'({LIT_WIDE_OUT, LITERAL_OUT}), 12'({cur[11:9] == 3'b101, elit(cur)}));
                end
            end
            w = (k < 10) ? corner[k] : 12'($urandom());
            c = 1'($urandom_range(1));
            @(posedge MCLK_IN);
            next_word <= w;
            COND_TRUE_IN <= c;
            repeat (3) @(negedge MCLK_IN);
            two = !dead && etwo(cur, c);
            if (!dead) chk(12'({CYCLES_OUT, FLUSH_OUT}), two ? 12'h005 : 12'h002);
            if (!two) k++;
            dead = two;
            cur = w;
        end
        results();
    end
endmodule : testbench
